// *** include/lic_pkg.sv ***
package lic_pkg;

  // ----------------------------------------------------------------
  // Register offsets in the CPU register file
  // ----------------------------------------------------------------
  localparam logic [7:0] LIC_ADDR_REQUEST_STATUS = 8'hdc;
  localparam logic [7:0] LIC_ADDR_LEVEL_MASK = 8'hdd;
  localparam logic [7:0] LIC_ADDR_SYSTEM_MODE = 8'hde;
  localparam logic [7:0] LIC_ADDR_LEVEL_PRIORITY = 8'hff;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int LIC_NUM_LEVELS = 8;
  localparam int LIC_NUM_SRC = 17;

  // ----------------------------------------------------------------
  // System mode fields
  // ----------------------------------------------------------------
  localparam int LIC_SYM_GLOBAL_EN_BIT = 0;
  localparam int LIC_SYM_FAST_EN_BIT = 1;
  localparam int LIC_SYM_FAST_SEL_LSB = 2;
  localparam int LIC_SYM_FAST_SEL_MSB = 4;

  // ----------------------------------------------------------------
  // Level priority fields
  // ----------------------------------------------------------------
  localparam int LIC_PRI_A_SWAP_BIT = 0;
  localparam int LIC_PRI_GRP_LO_BIT = 1;
  localparam int LIC_PRI_B_TOP_BIT = 2;
  localparam int LIC_PRI_B_SUB_BIT = 3;
  localparam int LIC_PRI_GRP_MID_BIT = 4;
  localparam int LIC_PRI_C_TOP_BIT = 5;
  localparam int LIC_PRI_C_SUB_BIT = 6;
  localparam int LIC_PRI_GRP_HI_BIT = 7;

  // Group ordering codes of bits {7,4,1}
  localparam logic [2:0] LIC_ORD_B_C_A = 3'h1;
  localparam logic [2:0] LIC_ORD_A_B_C = 3'h2;
  localparam logic [2:0] LIC_ORD_B_A_C = 3'h3;
  localparam logic [2:0] LIC_ORD_C_A_B = 3'h4;
  localparam logic [2:0] LIC_ORD_C_B_A = 3'h5;
  localparam logic [2:0] LIC_ORD_A_C_B = 3'h6;

  typedef enum logic [1:0] {
    LIC_GRP_A,
    LIC_GRP_B,
    LIC_GRP_C
  } lic_group_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LIC_RST_REQUEST_STATUS = 8'h00;
  localparam logic [7:0] LIC_RST_LEVEL_MASK = 8'h00;
  localparam logic [7:0] LIC_RST_SYSTEM_MODE = 8'h00;
  localparam logic [7:0] LIC_RST_LEVEL_PRIORITY = 8'h00;

  // ----------------------------------------------------------------
  // Source table, index order is vector order inside a level
  // 0 timer A capture, 1 timer A overflow, 2 timer B match,
  // 3 timer 0 match, 4 timer 0 overflow, 5 timer 1 capture,
  // 6 timer 1 overflow, 7 serial, 8 watch timer,
  // 9..12 port pins 0..3, 13..16 port pins 4..7
  // ----------------------------------------------------------------
  localparam logic [16:0][2:0] LIC_SRC_LEVEL = {
    3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h6, 3'h6, 3'h6, 3'h5,
    3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h1, 3'h0, 3'h0};
  // Sources whose pending flag hardware clears on acknowledge
  localparam logic [16:0] LIC_SRC_HW_CLEAR = 17'h00016;

endpackage

// *** src/lic_src_pending.sv ***
`timescale 1ns/1ns
module lic_src_pending (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [16:0] i_src_req,
  input wire logic [16:0] i_src_pend_clr,
  input wire logic [16:0] i_ack_onehot,
  output logic [16:0] o_pend
);

  logic [16:0] pend_q;
  logic [16:0] pend_d;

  // ----------------------------------------------------------------
  // Per-source pending flags, set wins over clear
  // ----------------------------------------------------------------
  for (genvar s = 0; s < lic_pkg::LIC_NUM_SRC; s++) begin : g_src
    always_comb begin
      if (lic_pkg::LIC_SRC_HW_CLEAR[s]) begin
        pend_d[s] = i_src_req[s] | (pend_q[s] & ~i_ack_onehot[s]);
      end else begin
        pend_d[s] = i_src_req[s] | (pend_q[s] & ~i_src_pend_clr[s]);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign o_pend = pend_q;

endmodule // lic_src_pending

// *** src/lic_prio_resolve.sv ***
`timescale 1ns/1ns
module lic_prio_resolve (
  input wire logic [7:0] i_level_req,
  input wire logic [7:0] i_level_mask,
  input wire logic [7:0] i_prio,
  output logic o_valid,
  output logic [2:0] o_level
);

  lic_pkg::lic_group_t grp_seq [3];
  logic [2:0] grp_a [2];
  logic [2:0] grp_b [3];
  logic [2:0] grp_c [3];
  logic [2:0] order [8];
  logic [7:0] live;

  // ----------------------------------------------------------------
  // Group and member ordering
  // ----------------------------------------------------------------
  always_comb begin
    int k;
    k = 0;
    grp_a[0] = i_prio[lic_pkg::LIC_PRI_A_SWAP_BIT] ? 3'h1 : 3'h0;
    grp_a[1] = i_prio[lic_pkg::LIC_PRI_A_SWAP_BIT] ? 3'h0 : 3'h1;
    if (i_prio[lic_pkg::LIC_PRI_B_TOP_BIT]) begin
      grp_b[0] = i_prio[lic_pkg::LIC_PRI_B_SUB_BIT] ? 3'h4 : 3'h3;
      grp_b[1] = i_prio[lic_pkg::LIC_PRI_B_SUB_BIT] ? 3'h3 : 3'h4;
      grp_b[2] = 3'h2;
    end else begin
      grp_b[0] = 3'h2;
      grp_b[1] = i_prio[lic_pkg::LIC_PRI_B_SUB_BIT] ? 3'h4 : 3'h3;
      grp_b[2] = i_prio[lic_pkg::LIC_PRI_B_SUB_BIT] ? 3'h3 : 3'h4;
    end
    if (i_prio[lic_pkg::LIC_PRI_C_TOP_BIT]) begin
      grp_c[0] = i_prio[lic_pkg::LIC_PRI_C_SUB_BIT] ? 3'h7 : 3'h6;
      grp_c[1] = i_prio[lic_pkg::LIC_PRI_C_SUB_BIT] ? 3'h6 : 3'h7;
      grp_c[2] = 3'h5;
    end else begin
      grp_c[0] = 3'h5;
      grp_c[1] = i_prio[lic_pkg::LIC_PRI_C_SUB_BIT] ? 3'h7 : 3'h6;
      grp_c[2] = i_prio[lic_pkg::LIC_PRI_C_SUB_BIT] ? 3'h6 : 3'h7;
    end
    case ({i_prio[lic_pkg::LIC_PRI_GRP_HI_BIT], i_prio[lic_pkg::LIC_PRI_GRP_MID_BIT],
           i_prio[lic_pkg::LIC_PRI_GRP_LO_BIT]})
      lic_pkg::LIC_ORD_B_C_A: grp_seq = '{lic_pkg::LIC_GRP_B, lic_pkg::LIC_GRP_C, lic_pkg::LIC_GRP_A};
      lic_pkg::LIC_ORD_B_A_C: grp_seq = '{lic_pkg::LIC_GRP_B, lic_pkg::LIC_GRP_A, lic_pkg::LIC_GRP_C};
      lic_pkg::LIC_ORD_C_A_B: grp_seq = '{lic_pkg::LIC_GRP_C, lic_pkg::LIC_GRP_A, lic_pkg::LIC_GRP_B};
      lic_pkg::LIC_ORD_C_B_A: grp_seq = '{lic_pkg::LIC_GRP_C, lic_pkg::LIC_GRP_B, lic_pkg::LIC_GRP_A};
      lic_pkg::LIC_ORD_A_C_B: grp_seq = '{lic_pkg::LIC_GRP_A, lic_pkg::LIC_GRP_C, lic_pkg::LIC_GRP_B};
      default: grp_seq = '{lic_pkg::LIC_GRP_A, lic_pkg::LIC_GRP_B, lic_pkg::LIC_GRP_C};
    endcase
    for (int i = 0; i < 8; i++) begin
      order[i] = 3'h0;
    end
    for (int g = 0; g < 3; g++) begin
      case (grp_seq[g])
        lic_pkg::LIC_GRP_A: begin
          for (int j = 0; j < 2; j++) begin
            order[k] = grp_a[j];
            k = k + 1;
          end
        end
        lic_pkg::LIC_GRP_B: begin
          for (int j = 0; j < 3; j++) begin
            order[k] = grp_b[j];
            k = k + 1;
          end
        end
        default: begin
          for (int j = 0; j < 3; j++) begin
            order[k] = grp_c[j];
            k = k + 1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // First live level in order wins
  // ----------------------------------------------------------------
  always_comb begin
    live = i_level_req & i_level_mask;
    o_valid = 1'b0;
    o_level = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (live[order[i]]) begin
        o_valid = 1'b1;
        o_level = order[i];
      end
    end
  end

endmodule // lic_prio_resolve

// *** src/lic_level_ctrl.sv ***
`timescale 1ns/1ns

// Overview of operation
// - Reset clears global and fast enable; fast level field value is don't care.
// - Enable and disable instructions set and clear global enable bit 0.
// - Mask bit n gates level n: 0 masks, 1 lets it through.
// - Highest priority level wins; inside a level lowest vector wins.
// - Levels grouped A=0..1, B=2..4, C=5..7 for priority setup.
// - Priority bits 7,4,1 order groups; 001 is B>C>A, 101 C>B>A.
// - Priority bit 5 orders group C; bit 6 orders its subgroup.
// - Priority bit 0 chooses between level 0 and level 1.
// - Status bit n reads 1 while level n has a request.
// - Status register is read-only, readable any time, zero after reset.
// - With global enable off, requests are recorded but not serviced.
// - Hardware-cleared flag sets on request and clears when acknowledged.
// - Hardware-cleared flags have no register bit of their own; they show only through their level's request status bit.
// - Software-cleared flags clear when their peripheral bit is written 0.
// - Timer 0 overflow is hardware-cleared; its register has enable only.
// - Each source has its own enable and maps to its fixed level.
// - System mode bits 4..2 pick the fast level; bit 1 enables it.
// - Qualified winner is acknowledged at instruction end, clearing global enable.
// - Interrupt return sets the global enable bit back to 1.
module lic_level_ctrl (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_global_enable_instr,
  input wire logic i_global_disable_instr,
  input wire logic i_interrupt_return_instr,
  input wire logic i_instr_end,
  input wire logic [16:0] i_src_req,
  input wire logic [16:0] i_src_en,
  input wire logic [16:0] i_src_pend_clr,
  output logic o_irq,
  output logic o_acknowledge_strobe,
  output logic [2:0] o_ack_level,
  output logic [4:0] o_ack_source,
  output logic o_ack_fast,
  output logic o_global_enable,
  output logic o_fast_enable
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] level_mask_reg_q;
  logic [7:0] level_mask_reg_d;
  logic [7:0] level_priority_reg_q;
  logic [7:0] level_priority_reg_d;
  logic [7:0] system_mode_reg_q;
  logic [7:0] system_mode_reg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic ack_q;
  logic ack_d;
  logic [2:0] ack_level_q;
  logic [2:0] ack_level_d;
  logic [4:0] ack_source_q;
  logic [4:0] ack_source_d;
  logic ack_fast_q;
  logic ack_fast_d;

  logic [16:0] src_pend;
  logic [16:0] src_live;
  logic [7:0] level_req;
  logic win_valid;
  logic [2:0] win_level;
  logic [4:0] win_source;
  logic ack_take;
  logic [16:0] ack_onehot;
  logic global_enable_bit;
  logic fast_enable_bit;
  logic [2:0] fast_sel;
  logic [7:0] fast_hit;

  assign global_enable_bit = system_mode_reg_q[lic_pkg::LIC_SYM_GLOBAL_EN_BIT];
  assign fast_enable_bit = system_mode_reg_q[lic_pkg::LIC_SYM_FAST_EN_BIT];
  assign fast_sel = system_mode_reg_q[lic_pkg::LIC_SYM_FAST_SEL_MSB:lic_pkg::LIC_SYM_FAST_SEL_LSB];

  // ----------------------------------------------------------------
  // Source pending flags
  // ----------------------------------------------------------------
  lic_src_pending u_pending (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_src_req(i_src_req),
    .i_src_pend_clr(i_src_pend_clr),
    .i_ack_onehot(ack_onehot),
    .o_pend(src_pend)
  );

  // ----------------------------------------------------------------
  // Level requests from enabled pending sources
  // ----------------------------------------------------------------
  assign src_live = src_pend & i_src_en;

  for (genvar l = 0; l < lic_pkg::LIC_NUM_LEVELS; l++) begin : g_level
    logic [16:0] member;
    for (genvar s = 0; s < lic_pkg::LIC_NUM_SRC; s++) begin : g_member
      assign member[s] = (lic_pkg::LIC_SRC_LEVEL[s] == 3'(l));
    end
    // Mask is not applied, so masked events stay visible to polling
    assign level_req[l] = |(src_live & member);
  end

  // ----------------------------------------------------------------
  // Level arbitration
  // ----------------------------------------------------------------
  lic_prio_resolve u_resolve (
    .i_level_req(level_req),
    .i_level_mask(level_mask_reg_q),
    .i_prio(level_priority_reg_q),
    .o_valid(win_valid),
    .o_level(win_level)
  );

  // Lowest index, which is lowest vector, inside the winning level
  always_comb begin
    win_source = 5'h00;
    for (int s = lic_pkg::LIC_NUM_SRC - 1; s >= 0; s--) begin
      if (src_live[s] && (lic_pkg::LIC_SRC_LEVEL[s] == win_level)) begin
        win_source = 5'(s);
      end
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge at the instruction boundary
  // ----------------------------------------------------------------
  // One fast-select match flag per level
  for (genvar l = 0; l < lic_pkg::LIC_NUM_LEVELS; l++) begin : g_fast
    assign fast_hit[l] = fast_enable_bit && (fast_sel == 3'(l));
  end

  always_comb begin
    ack_take = i_instr_end && global_enable_bit && win_valid;
    ack_onehot = '0;
    ack_level_d = ack_level_q;
    ack_source_d = ack_source_q;
    ack_fast_d = ack_fast_q;
    if (ack_take) begin
      ack_onehot[win_source] = 1'b1;
      ack_level_d = win_level;
      ack_source_d = win_source;
      ack_fast_d = fast_hit[win_level];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack_level_q <= 3'h0;
      ack_source_q <= 5'h00;
      ack_fast_q <= 1'b0;
    end else begin
      ack_level_q <= ack_level_d;
      ack_source_q <= ack_source_d;
      ack_fast_q <= ack_fast_d;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge strobe, high for one cycle per acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    ack_d = ack_take;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // ----------------------------------------------------------------
  // Request line to the core, dropped while globally disabled
  // ----------------------------------------------------------------
  always_comb begin
    irq_d = global_enable_bit && win_valid;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Level mask register
  // ----------------------------------------------------------------
  always_comb begin
    level_mask_reg_d = level_mask_reg_q;
    if (i_reg_wr && (i_reg_addr == lic_pkg::LIC_ADDR_LEVEL_MASK)) begin
      level_mask_reg_d = i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      level_mask_reg_q <= lic_pkg::LIC_RST_LEVEL_MASK;
    end else begin
      level_mask_reg_q <= level_mask_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // Level priority register
  // ----------------------------------------------------------------
  always_comb begin
    level_priority_reg_d = level_priority_reg_q;
    if (i_reg_wr && (i_reg_addr == lic_pkg::LIC_ADDR_LEVEL_PRIORITY)) begin
      level_priority_reg_d = i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      level_priority_reg_q <= lic_pkg::LIC_RST_LEVEL_PRIORITY;
    end else begin
      level_priority_reg_q <= level_priority_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // System mode register and global enable control
  // ----------------------------------------------------------------
  always_comb begin
    system_mode_reg_d = system_mode_reg_q;
    if (i_reg_wr && (i_reg_addr == lic_pkg::LIC_ADDR_SYSTEM_MODE)) begin
      system_mode_reg_d = i_reg_wdata;
    end
    // Later lines win: write, enable or return, disable, acknowledge
    if (i_global_enable_instr || i_interrupt_return_instr) begin
      system_mode_reg_d[lic_pkg::LIC_SYM_GLOBAL_EN_BIT] = 1'b1;
    end
    if (i_global_disable_instr) begin
      system_mode_reg_d[lic_pkg::LIC_SYM_GLOBAL_EN_BIT] = 1'b0;
    end
    if (ack_take) begin
      system_mode_reg_d[lic_pkg::LIC_SYM_GLOBAL_EN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      system_mode_reg_q <= lic_pkg::LIC_RST_SYSTEM_MODE;
    end else begin
      system_mode_reg_q <= system_mode_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      case (i_reg_addr)
        lic_pkg::LIC_ADDR_REQUEST_STATUS: rdata_d = level_req;
        lic_pkg::LIC_ADDR_LEVEL_MASK: rdata_d = level_mask_reg_q;
        lic_pkg::LIC_ADDR_SYSTEM_MODE: rdata_d = system_mode_reg_q;
        lic_pkg::LIC_ADDR_LEVEL_PRIORITY: rdata_d = level_priority_reg_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdata_q <= lic_pkg::LIC_RST_REQUEST_STATUS;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_acknowledge_strobe = ack_q;
  assign o_ack_level = ack_level_q;
  assign o_ack_source = ack_source_q;
  assign o_ack_fast = ack_fast_q;
  assign o_global_enable = system_mode_reg_q[lic_pkg::LIC_SYM_GLOBAL_EN_BIT];
  assign o_fast_enable = system_mode_reg_q[lic_pkg::LIC_SYM_FAST_EN_BIT];

endmodule // lic_level_ctrl

// *** test/lic_level_ctrl_properties.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Acknowledge, enable and read-back checks
// ----------------------------------------
module lic_level_ctrl_checker (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_global_enable_instr,
  input wire logic i_global_disable_instr,
  input wire logic i_interrupt_return_instr,
  input wire logic i_instr_end,
  input wire logic [16:0] i_src_req,
  input wire logic [16:0] i_src_en,
  input wire logic [16:0] i_src_pend_clr,
  input wire logic o_irq,
  input wire logic o_acknowledge_strobe,
  input wire logic [2:0] o_ack_level,
  input wire logic [4:0] o_ack_source,
  input wire logic o_ack_fast,
  input wire logic o_global_enable,
  input wire logic o_fast_enable
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  a_ack_gate: assert property (
    o_acknowledge_strobe |-> $past(o_global_enable) && $past(i_instr_end))
    else $error("Acknowledge without enable or boundary");
  a_ack_clears_enable: assert property (o_acknowledge_strobe |-> !o_global_enable)
    else $error("Global enable still set at acknowledge");
  a_strobe_single: assert property (o_acknowledge_strobe |=> !o_acknowledge_strobe)
    else $error("Acknowledge strobe longer than one cycle");
  a_enable_sets_bit: assert property (
    i_global_enable_instr && !i_global_disable_instr && !i_instr_end |=> o_global_enable)
    else $error("Enable instruction did not set global enable");
  a_disable_clears_bit: assert property (i_global_disable_instr |=> !o_global_enable)
    else $error("Disable instruction did not clear global enable");
  a_return_sets_bit: assert property (
    i_interrupt_return_instr && !i_global_disable_instr && !i_instr_end |=> o_global_enable)
    else $error("Return did not set global enable");
  a_ack_fields_hold: assert property (
    !o_acknowledge_strobe |-> $stable(o_ack_level) && $stable(o_ack_source))
    else $error("Acknowledge fields changed without strobe");
  a_level_of_source: assert property (
    o_acknowledge_strobe |-> o_ack_level == lic_pkg::LIC_SRC_LEVEL[o_ack_source])
    else $error("Acknowledged level does not match source");
  a_fast_needs_enable: assert property (
    o_acknowledge_strobe && o_ack_fast |-> $past(o_fast_enable))
    else $error("Fast acknowledge while fast processing off");
  a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("Read data changed without a read");

  c_ack_seen: cover property (o_acknowledge_strobe);
  c_fast_ack: cover property (o_acknowledge_strobe && o_ack_fast);
  c_boundary_disabled: cover property (!o_global_enable && i_instr_end && o_reg_rdata != 8'h00);
endmodule // lic_level_ctrl_checker

// *** test/lic_cpu_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Service routine of the CPU side
// ----------------------------------------
module lic_cpu_model (
  input wire logic i_mclk,
  input wire logic i_auto,
  input wire logic [3:0] i_delay,
  input wire logic i_ack_strobe,
  input wire logic [4:0] i_ack_source,
  output logic [16:0] o_src_pend_clr,
  output logic o_return_instr
);
  initial begin
    o_src_pend_clr = 17'h00000;
    o_return_instr = 1'b0;
    forever begin
      @(negedge i_mclk);
      if (i_auto && i_ack_strobe === 1'b1) begin
        repeat (i_delay) @(negedge i_mclk);
        // Software-cleared sources get their pending bit written 0 before return
        if (!lic_pkg::LIC_SRC_HW_CLEAR[i_ack_source]) begin
          o_src_pend_clr[i_ack_source] = 1'b1;
        end
        @(negedge i_mclk);
        o_src_pend_clr = 17'h00000;
        o_return_instr = 1'b1;
        @(negedge i_mclk);
        o_return_instr = 1'b0;
      end
    end
  end
endmodule // lic_cpu_model

// *** test/lic_level_ctrl_tb.sv ***
`timescale 1ns/1ns
module lic_level_ctrl_tb;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [3:0] ctl = 4'h0;
  logic [16:0] i_src_req = 17'h00000;
  logic [16:0] i_src_en = 17'h1ffff;
  logic [16:0] clr_tb = 17'h00000;
  logic auto_svc = 1'b0;
  logic [16:0] m_clr, i_src_pend_clr;
  logic m_ret, i_interrupt_return_instr, i_instr_end;
  logic i_global_enable_instr, i_global_disable_instr;
  logic [7:0] o_reg_rdata;
  logic o_irq, o_acknowledge_strobe, o_ack_fast, o_global_enable, o_fast_enable;
  logic [2:0] o_ack_level;
  logic [4:0] o_ack_source;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // Priority cases: level priority value, requests, expected {level, source}
  logic [7:0] pr [12] = '{8'h02, 8'h82, 8'h01, 8'h00, 8'ha2, 8'he2, 8'h0c, 8'h12,
                          8'h80, 8'h90, 8'h04, 8'h40};
  logic [16:0] rq [12] = '{17'h00121, 17'h00224, 17'h00005, 17'h00005,
                           17'h02100, 17'h02200, 17'h000a8, 17'h00081,
                           17'h00109, 17'h00208, 17'h000c8, 17'h02200};
  logic [7:0] ex [12] = '{8'h65, 8'hc9, 8'h22, 8'h00, 8'hed, 8'hed, 8'h87, 8'h87,
                          8'ha8, 8'hc9, 8'h66, 8'hed};

  assign i_instr_end = ctl[0];
  assign i_global_enable_instr = ctl[1];
  assign i_global_disable_instr = ctl[2];
  assign i_interrupt_return_instr = ctl[3] | m_ret;
  assign i_src_pend_clr = clr_tb | m_clr;

  lic_level_ctrl dut_u (.*);
  lic_cpu_model cpu_u (.i_mclk(i_mclk), .i_auto(auto_svc), .i_delay(4'h3),
    .i_ack_strobe(o_acknowledge_strobe), .i_ack_source(o_ack_source),
    .o_src_pend_clr(m_clr), .o_return_instr(m_ret));

  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rst(input int n);
    @(negedge i_mclk);
    i_reset = 1'b1;
    repeat (n) @(negedge i_mclk);
    i_reset = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_mclk);
    i_reg_rd = 1'b0;
    @(negedge i_mclk);
    chk({8'h00, o_reg_rdata & m}, {8'h00, e});
  endtask
  task automatic pulse(input int k);
    @(negedge i_mclk);
    ctl[k] = 1'b1;
    @(negedge i_mclk);
    ctl[k] = 1'b0;
  endtask
  task automatic fire(input logic [16:0] v, input logic c);
    @(negedge i_mclk);
    if (c) clr_tb = v;
    else i_src_req = v;
    @(negedge i_mclk);
    clr_tb = 17'h00000;
    i_src_req = 17'h00000;
    repeat (2) @(negedge i_mclk);
  endtask
  // Instruction boundary; looks for the strobe over the next three cycles
  task automatic ack(input logic e, input logic [7:0] es);
    logic seen;
    seen = 1'b0;
    @(negedge i_mclk);
    ctl[0] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(negedge i_mclk);
      ctl[0] = 1'b0;
      if (o_acknowledge_strobe === 1'b1) seen = 1'b1;
    end
    chk({15'h0, seen}, {15'h0, e});
    if (e) chk({8'h00, o_ack_level, o_ack_source}, {8'h00, es});
  endtask

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst(20);
    chk({14'h0, o_global_enable, o_fast_enable}, 16'h0000);
    rd(8'hdc, 8'hff, 8'h00);
    rd(8'hde, 8'h03, 8'h00);
    wr(8'hdc, 8'hff);
    rd(8'hdc, 8'hff, 8'h00);
    rd(8'h10, 8'hff, 8'h00);
    wr(8'hdd, 8'h5a);
    rd(8'hdd, 8'hff, 8'h5a);
    wr(8'hff, 8'ha5);
    rd(8'hff, 8'hff, 8'ha5);
    wr(8'hff, 8'h00);
    wr(8'hdd, 8'hff);
    pulse(1);
    rd(8'hde, 8'h01, 8'h01);
    pulse(2);
    rd(8'hde, 8'h01, 8'h00);
    i_src_en = 17'h1ff7f;
    fire(17'h00080, 1'b0);
    rd(8'hdc, 8'hff, 8'h00);
    i_src_en = 17'h1ffff;
    rd(8'hdc, 8'hff, 8'h10);
    ack(1'b0, 8'h00);
    chk({15'h0, o_irq}, 16'h0000);
    pulse(1);
    wr(8'hdd, 8'hef);
    ack(1'b0, 8'h00);
    wr(8'hdd, 8'hff);
    repeat (2) @(negedge i_mclk);
    chk({15'h0, o_irq}, 16'h0001);
    ack(1'b1, 8'h87);
    chk({15'h0, o_global_enable}, 16'h0000);
    rd(8'hdc, 8'hff, 8'h10);
    fire(17'h00080, 1'b1);
    rd(8'hdc, 8'hff, 8'h00);
    pulse(3);
    chk({15'h0, o_global_enable}, 16'h0001);
    fire(17'h00010, 1'b0);
    ack(1'b1, 8'h44);
    rd(8'hdc, 8'hff, 8'h00);
    wr(8'hde, 8'h0b);
    auto_svc = 1'b1;
    fire(17'h00030, 1'b0);
    ack(1'b1, 8'h44);
    chk({14'h0, o_ack_fast, o_fast_enable}, 16'h0003);
    repeat (8) @(negedge i_mclk);
    ack(1'b1, 8'h65);
    chk({15'h0, o_ack_fast}, 16'h0000);
    repeat (8) @(negedge i_mclk);
    rd(8'hdc, 8'hff, 8'h00);
    auto_svc = 1'b0;
    fire(17'h00a00, 1'b0);
    ack(1'b1, 8'hc9);
    for (int k = 0; k < 12; k++) begin
      rst(2);
      wr(8'hdd, 8'hff);
      wr(8'hff, pr[k]);
      pulse(1);
      fire(rq[k], 1'b0);
      ack(1'b1, ex[k]);
    end
    tally_and_finish();
  end
endmodule // lic_level_ctrl_tb

bind lic_level_ctrl lic_level_ctrl_checker chk_u (.*);
